// File: lfu_regs.svh
// Register offsets, field positions and reset values of the linear pixel window
`ifndef LFU_REGS_SVH
`define LFU_REGS_SVH
`define LFU_ADDR_MODE    12'h000
`define LFU_ADDR_CONST   12'h004
`define LFU_ADDR_RENDER  12'h008
`define LFU_ADDR_HEIGHT  12'h00c
`define LFU_ADDR_STATUS  12'h010
`define LFU_MODE_RST     17'h00000
`define LFU_CONST_RST    32'h00000000
`define LFU_RENDER_RST   2'h0
`define LFU_HEIGHT_RST   10'h3ff
`define LFU_FMT_HI       3
`define LFU_FMT_LO       0
`define LFU_WBUF_HI      5
`define LFU_WBUF_LO      4
`define LFU_RBUF_HI      7
`define LFU_RBUF_LO      6
`define LFU_PIPE         8
`define LFU_LANE_HI      10
`define LFU_LANE_LO      9
`define LFU_WSWAP        11
`define LFU_WSWIZ        12
`define LFU_YORG         13
`define LFU_WSEL         14
`define LFU_RSWAP        15
`define LFU_RSWIZ        16
`define LFU_RND_YORG     17
`define LFU_RND_ABUF     18
`define LFU_X16_HI       10
`define LFU_X16_LO       2
`define LFU_Y16_HI       20
`define LFU_Y16_LO       11
`define LFU_X32_HI       11
`define LFU_X32_LO       2
`define LFU_Y32_HI       21
`define LFU_Y32_LO       12
`define LFU_RBUF_DEPTH   2'h2
`define LFU_RBUF_RSVD    2'h3
`endif

// File: lfu_pkg.sv
// Types shared by the linear pixel window logic
`default_nettype none
package lfu_pkg;
	typedef enum logic [3:0] {
		LFU_F565 = 4'h0, LFU_F555 = 4'h1, LFU_F1555 = 4'h2, LFU_F888 = 4'h4,
		LFU_F8888 = 4'h5, LFU_Z565 = 4'hc, LFU_Z555 = 4'hd, LFU_Z1555 = 4'he,
		LFU_ZZ = 4'hf
	} lfu_fmt_t;
	typedef enum logic {LFU_IDLE, LFU_SECOND} lfu_beat_t;
endpackage
`default_nettype wire

// File: lfu_unpacker.sv
// Linear pixel window write unpacker and read path with APB register file
`timescale 1ns/1ps
`default_nettype none
`include "lfu_regs.svh"

module lfu_unpacker
	import lfu_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        win_wr_valid,
	output logic             win_wr_ready,
	input  wire logic [21:0] win_wr_addr,
	input  wire logic [31:0] win_wr_data,
	input  wire logic        win_rd_req,
	output logic             win_rd_ready,
	input  wire logic [21:0] win_rd_addr,
	output var  logic        win_rd_valid,
	output var  logic [31:0] win_rd_data,
	output var  logic        mem_rd_req,
	output var  logic [9:0]  mem_rd_x,
	output var  logic [9:0]  mem_rd_y,
	output var  logic [1:0]  mem_rd_buf,
	input  wire logic        mem_rd_valid,
	input  wire logic [31:0] mem_rd_data,
	output var  logic        pix_valid,
	output var  logic [9:0]  pix_x,
	output var  logic [9:0]  pix_y,
	output var  logic [1:0]  pix_buf,
	output var  logic        pix_pipe,
	output var  logic        pix_color_we,
	output var  logic        pix_depth_we,
	output var  logic        pix_alpha_we,
	output var  logic [7:0]  pix_r,
	output var  logic [7:0]  pix_g,
	output var  logic [7:0]  pix_b,
	output var  logic [7:0]  pix_a,
	output var  logic [15:0] pix_depth,
	output var  logic [15:0] pix_w
);
	logic [16:0] linear_access_mode;
	logic [31:0] const_depth_alpha;
	logic [1:0]  pixel_render_mode;
	logic [9:0]  screen_height;
	logic [15:0] discard_count;
	lfu_beat_t   beat;
	logic [15:0] hold_hi;
	logic [16:0] hold_mode;
	logic [9:0]  hold_x;
	logic [9:0]  hold_y;
	logic        rd_busy;
	logic [3:0]  out_fmt;

	// Colour unpack of one pixel: channel order set by the lane field
	function automatic logic [31:0] lfu_colour(input logic [31:0] w, input logic [3:0] fmt,
		input logic [1:0] lane);
		logic [7:0] a;
		logic [7:0] c0;
		logic [7:0] g;
		logic [7:0] c2;
		a = 8'hff;
		case (fmt)
			LFU_F565, LFU_Z565: begin
				c0 = {w[15:11], w[15:13]};
				g  = {w[10:5], w[10:9]};
				c2 = {w[4:0], w[4:2]};
			end
			LFU_F555, LFU_F1555, LFU_Z555, LFU_Z1555: begin
				if (!lane[1]) begin
					c0 = {w[14:10], w[14:12]};
					g  = {w[9:5], w[9:7]};
					c2 = {w[4:0], w[4:2]};
					a  = {8{w[15]}};
				end else begin
					c0 = {w[15:11], w[15:13]};
					g  = {w[10:6], w[10:8]};
					c2 = {w[5:1], w[5:3]};
					a  = {8{w[0]}};
				end
			end
			default: begin
				if (!lane[1]) begin
					a  = w[31:24];
					c0 = w[23:16];
					g  = w[15:8];
					c2 = w[7:0];
				end else begin
					c0 = w[31:24];
					g  = w[23:16];
					c2 = w[15:8];
					a  = w[7:0];
				end
			end
		endcase
		return lane[0] ? {a, c2, g, c0} : {a, c0, g, c2};
	endfunction

	// APB access decode
	logic wr_en;
	logic mapped;
	assign wr_en  = psel && penable && pwrite;
	assign pready = 1'b1;
	always_comb begin
		if (paddr == `LFU_ADDR_MODE) begin
			mapped = 1'b1;
		end else if (paddr == `LFU_ADDR_CONST) begin
			mapped = 1'b1;
		end else if (paddr == `LFU_ADDR_RENDER) begin
			mapped = 1'b1;
		end else if (paddr == `LFU_ADDR_HEIGHT) begin
			mapped = 1'b1;
		end else if (paddr == `LFU_ADDR_STATUS) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			linear_access_mode <= `LFU_MODE_RST;
			const_depth_alpha  <= `LFU_CONST_RST;
			pixel_render_mode  <= `LFU_RENDER_RST;
			screen_height      <= `LFU_HEIGHT_RST;
		end else if (wr_en) begin
			if (paddr == `LFU_ADDR_MODE) begin
				linear_access_mode <= pwdata[16:0];
			end else if (paddr == `LFU_ADDR_CONST) begin
				const_depth_alpha <= pwdata;
			end else if (paddr == `LFU_ADDR_RENDER) begin
				pixel_render_mode <= pwdata[`LFU_RND_ABUF:`LFU_RND_YORG];
			end else if (paddr == `LFU_ADDR_HEIGHT) begin
				screen_height <= pwdata[9:0];
			end
		end
	end

	// Read data is latched in the setup phase so that it comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			if (paddr == `LFU_ADDR_MODE) begin
				prdata <= {15'h0, linear_access_mode};
			end else if (paddr == `LFU_ADDR_CONST) begin
				prdata <= const_depth_alpha;
			end else if (paddr == `LFU_ADDR_RENDER) begin
				prdata <= {13'h0, pixel_render_mode, 17'h0};
			end else if (paddr == `LFU_ADDR_HEIGHT) begin
				prdata <= {22'h0, screen_height};
			end else if (paddr == `LFU_ADDR_STATUS) begin
				prdata <= {discard_count, 14'h0, rd_busy, beat == LFU_SECOND};
			end else begin
				prdata <= 32'h0;
			end
		end
	end

	// Incoming word: swizzle, then half swap (skipped for 32-bit colour)
	logic [3:0]  in_fmt;
	logic [31:0] swz_word;
	logic [31:0] proc_word;
	logic        swap_en;
	logic        two_pix;
	logic        discard;
	logic        acc;
	logic        flip_w;
	logic [9:0]  raw_x;
	logic [9:0]  raw_y;
	logic [9:0]  fin_y;
	assign in_fmt   = linear_access_mode[`LFU_FMT_HI:`LFU_FMT_LO];
	assign swz_word = linear_access_mode[`LFU_WSWIZ] ?
		{win_wr_data[7:0], win_wr_data[15:8], win_wr_data[23:16], win_wr_data[31:24]} :
		win_wr_data;
	assign swap_en  = linear_access_mode[`LFU_WSWAP] && in_fmt != LFU_F888 &&
		in_fmt != LFU_F8888;
	assign proc_word = swap_en ? {swz_word[15:0], swz_word[31:16]} : swz_word;
	assign two_pix  = in_fmt == LFU_F565 || in_fmt == LFU_F555 || in_fmt == LFU_F1555 ||
		in_fmt == LFU_ZZ;
	assign discard  = !(two_pix || in_fmt == LFU_F888 || in_fmt == LFU_F8888 ||
		in_fmt == LFU_Z565 || in_fmt == LFU_Z555 || in_fmt == LFU_Z1555) ||
		linear_access_mode[`LFU_WBUF_HI];
	assign win_wr_ready = beat == LFU_IDLE;
	assign acc      = win_wr_valid && win_wr_ready;
	// Offset to x,y: 16-bit pixels pair on an even x, 32-bit pixels take a word each
	assign raw_x = two_pix ? {win_wr_addr[`LFU_X16_HI:`LFU_X16_LO], 1'b0} :
		win_wr_addr[`LFU_X32_HI:`LFU_X32_LO];
	assign raw_y = two_pix ? win_wr_addr[`LFU_Y16_HI:`LFU_Y16_LO] :
		win_wr_addr[`LFU_Y32_HI:`LFU_Y32_LO];
	assign flip_w = linear_access_mode[`LFU_PIPE] ? pixel_render_mode[0] :
		linear_access_mode[`LFU_YORG];
	assign fin_y = flip_w ? screen_height - raw_y : raw_y;

	// Second beat carries the upper half of a packed word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			beat <= LFU_IDLE;
		end else begin
			case (beat)
				LFU_IDLE: begin
					if (acc && two_pix && !discard) begin
						beat <= LFU_SECOND;
					end
				end
				default: begin
					beat <= LFU_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_hi   <= 16'h0;
			hold_mode <= `LFU_MODE_RST;
			hold_x    <= 10'h0;
			hold_y    <= 10'h0;
		end else if (acc) begin
			hold_hi   <= proc_word[31:16];
			hold_mode <= linear_access_mode;
			hold_x    <= raw_x + 10'h1;
			hold_y    <= fin_y;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			discard_count <= 16'h0;
		end else if (acc && discard) begin
			discard_count <= discard_count + 16'h1;
		end
	end

	// Per-pixel field build for the current beat
	logic        second;
	logic [16:0] cur_mode;
	logic [31:0] cur_word;
	logic [3:0]  cur_fmt;
	logic [31:0] cur_col;
	logic        has_alpha;
	logic        has_depth;
	logic        abuf;
	logic [15:0] next_depth;
	logic [7:0]  next_alpha;
	logic [15:0] next_w;
	logic        next_cwe;
	logic        next_dwe;
	logic        next_awe;
	assign second   = beat == LFU_SECOND;
	assign cur_mode = second ? hold_mode : linear_access_mode;
	assign cur_word = second ? {16'h0, hold_hi} : proc_word;
	assign cur_fmt  = cur_mode[`LFU_FMT_HI:`LFU_FMT_LO];
	assign cur_col  = lfu_colour(cur_word, cur_fmt, cur_mode[`LFU_LANE_HI:`LFU_LANE_LO]);
	assign has_alpha = cur_fmt == LFU_F1555 || cur_fmt == LFU_F8888 || cur_fmt == LFU_Z1555;
	assign has_depth = cur_fmt[3:2] == 2'h3;
	assign abuf      = pixel_render_mode[1];

	always_comb begin
		next_depth = cur_fmt == LFU_ZZ ? cur_word[15:0] : cur_word[31:16];
		next_alpha = cur_col[31:24];
		if (cur_mode[`LFU_PIPE]) begin
			if (!has_depth) begin
				next_depth = const_depth_alpha[15:0];
			end
			if (!has_alpha) begin
				next_alpha = const_depth_alpha[31:24];
			end
			next_cwe = 1'b1;
			next_dwe = 1'b1;
			next_awe = 1'b1;
			next_w   = cur_mode[`LFU_WSEL] ? const_depth_alpha[15:0] : next_depth;
		end else begin
			next_cwe = cur_fmt != LFU_ZZ;
			next_dwe = has_depth && !(cur_fmt == LFU_Z1555 && abuf);
			next_awe = has_alpha && abuf;
			next_w   = next_depth;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_valid    <= 1'b0;
			pix_x        <= 10'h0;
			pix_y        <= 10'h0;
			pix_buf      <= 2'h0;
			pix_pipe     <= 1'b0;
			pix_color_we <= 1'b0;
			pix_depth_we <= 1'b0;
			pix_alpha_we <= 1'b0;
			pix_r        <= 8'h0;
			pix_g        <= 8'h0;
			pix_b        <= 8'h0;
			pix_a        <= 8'h0;
			pix_depth    <= 16'h0;
			pix_w        <= 16'h0;
			out_fmt      <= 4'h0;
		end else begin
			pix_valid <= (acc && !discard) || second;
			if ((acc && !discard) || second) begin
				pix_x        <= second ? hold_x : raw_x;
				pix_y        <= second ? hold_y : fin_y;
				pix_buf      <= cur_mode[`LFU_WBUF_HI:`LFU_WBUF_LO];
				pix_pipe     <= cur_mode[`LFU_PIPE];
				pix_color_we <= next_cwe;
				pix_depth_we <= next_dwe;
				pix_alpha_we <= next_awe;
				pix_r        <= cur_fmt == LFU_ZZ ? 8'h0 : cur_col[23:16];
				pix_g        <= cur_fmt == LFU_ZZ ? 8'h0 : cur_col[15:8];
				pix_b        <= cur_fmt == LFU_ZZ ? 8'h0 : cur_col[7:0];
				pix_a        <= next_alpha;
				pix_depth    <= next_depth;
				pix_w        <= next_w;
				out_fmt      <= cur_fmt;
			end
		end
	end

	// Read path: one read outstanding; a reserved buffer answers zero at once
	logic       rd_acc;
	logic [1:0] rd_buf;
	logic [9:0] rd_y;
	logic       rd_rsvd;
	logic [31:0] rd_swz;
	assign win_rd_ready = !rd_busy;
	assign rd_acc  = win_rd_req && !rd_busy;
	assign rd_buf  = linear_access_mode[`LFU_RBUF_HI:`LFU_RBUF_LO];
	assign rd_y    = linear_access_mode[`LFU_YORG] ?
		screen_height - win_rd_addr[`LFU_Y16_HI:`LFU_Y16_LO] :
		win_rd_addr[`LFU_Y16_HI:`LFU_Y16_LO];
	assign rd_rsvd = rd_buf == `LFU_RBUF_RSVD;
	assign rd_swz  = linear_access_mode[`LFU_RSWIZ] ?
		{mem_rd_data[7:0], mem_rd_data[15:8], mem_rd_data[23:16], mem_rd_data[31:24]} :
		mem_rd_data;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_busy      <= 1'b0;
			mem_rd_req   <= 1'b0;
			mem_rd_x     <= 10'h0;
			mem_rd_y     <= 10'h0;
			mem_rd_buf   <= 2'h0;
			win_rd_valid <= 1'b0;
			win_rd_data  <= 32'h0;
		end else begin
			mem_rd_req   <= rd_acc && !rd_rsvd;
			win_rd_valid <= (rd_acc && rd_rsvd) || (rd_busy && mem_rd_valid);
			if (rd_acc) begin
				rd_busy    <= !rd_rsvd;
				mem_rd_x   <= {win_rd_addr[`LFU_X16_HI:`LFU_X16_LO], 1'b0};
				mem_rd_y   <= rd_y;
				mem_rd_buf <= rd_buf;
				win_rd_data <= 32'h0;
			end else if (rd_busy && mem_rd_valid) begin
				rd_busy     <= 1'b0;
				win_rd_data <= linear_access_mode[`LFU_RSWAP] ?
					{rd_swz[15:0], rd_swz[31:16]} : rd_swz;
			end
		end
	end

	property p_reserved_drop;
		@(posedge pclk) disable iff (!presetn)
		acc && discard |=> !pix_valid;
	endproperty
	a_reserved_drop: assert property (p_reserved_drop) else $error("reserved write produced a pixel");

	property p_zz_no_colour;
		@(posedge pclk) disable iff (!presetn)
		pix_valid && !pix_pipe && out_fmt == 4'hf |-> !pix_color_we && pix_depth_we;
	endproperty
	a_zz_no_colour: assert property (p_zz_no_colour) else $error("depth-only format wrote colour");

	property p_colour_no_depth;
		@(posedge pclk) disable iff (!presetn)
		pix_valid && !pix_pipe && (out_fmt <= 4'h2 || out_fmt == 4'h4) |-> !pix_depth_we && pix_color_we;
	endproperty
	a_colour_no_depth: assert property (p_colour_no_depth) else $error("colour format wrote depth");

	property p_zc_both;
		@(posedge pclk) disable iff (!presetn)
		pix_valid && !pix_pipe && (out_fmt == 4'hc || out_fmt == 4'hd) |-> pix_color_we && pix_depth_we;
	endproperty
	a_zc_both: assert property (p_zc_both) else $error("depth+colour format missed a buffer");

	property p_z1555_one;
		@(posedge pclk) disable iff (!presetn)
		pix_valid && !pix_pipe && out_fmt == 4'he |-> pix_depth_we != pix_alpha_we;
	endproperty
	a_z1555_one: assert property (p_z1555_one) else $error("format 14 kept both depth and alpha");

	property p_pipe_all;
		@(posedge pclk) disable iff (!presetn)
		pix_valid && pix_pipe |-> pix_color_we && pix_depth_we && pix_alpha_we;
	endproperty
	a_pipe_all: assert property (p_pipe_all) else $error("pipeline pixel lacks an enable");

	property p_pair;
		@(posedge pclk) disable iff (!presetn)
		acc && two_pix && !discard |=> (pix_valid && !win_wr_ready) ##1
			(pix_valid && pix_x == $past(pix_x) + 10'h1);
	endproperty
	a_pair: assert property (p_pair) else $error("packed word did not give two pixels");

	property p_wconst;
		@(posedge pclk) disable iff (!presetn)
		acc && !discard && linear_access_mode[`LFU_PIPE] && linear_access_mode[`LFU_WSEL]
			|=> pix_w == $past(const_depth_alpha[15:0]);
	endproperty
	a_wconst: assert property (p_wconst) else $error("W not taken from constant");

	property p_rd_answer;
		@(posedge pclk) disable iff (!presetn)
		rd_acc && rd_rsvd |=> win_rd_valid && win_rd_data == 32'h0 && !mem_rd_req;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("reserved read not answered");

	c_pair: cover property (@(posedge pclk) disable iff (!presetn) acc && two_pix ##1 second);
	c_z1555: cover property (@(posedge pclk) disable iff (!presetn) pix_valid && out_fmt == 4'he);
	c_pipe: cover property (@(posedge pclk) disable iff (!presetn) pix_valid && pix_pipe);
	c_read: cover property (@(posedge pclk) disable iff (!presetn) mem_rd_req ##[1:4] win_rd_valid);
endmodule
`default_nettype wire

// File: lfu_mem_model.sv
// Pixel memory responder that answers read requests of the window read path
`timescale 1ns/1ps
`default_nettype none

module lfu_mem_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        mem_rd_req,
	input  wire logic [9:0]  mem_rd_x,
	input  wire logic [9:0]  mem_rd_y,
	input  wire logic [1:0]  mem_rd_buf,
	input  wire logic [3:0]  lat,
	output var  logic        mem_rd_valid,
	output var  logic [31:0] mem_rd_data
);
	logic [3:0]  cnt;
	logic        pend;
	logic [31:0] word;

	// Answer word encodes buffer and position; data lines toggle outside answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= 1'b0;
			cnt <= 4'h0;
			word <= 32'h0;
			mem_rd_valid <= 1'b0;
			mem_rd_data <= 32'h0;
		end else begin
			mem_rd_valid <= 1'b0;
			mem_rd_data <= ~mem_rd_data;
			if (mem_rd_req) begin
				pend <= 1'b1;
				cnt <= lat;
				word <= {mem_rd_buf, 4'h5, mem_rd_y, 6'h00, mem_rd_x};
			end else if (pend && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (pend) begin
				pend <= 1'b0;
				mem_rd_valid <= 1'b1;
				mem_rd_data <= word;
			end
		end
	end
endmodule

`default_nettype wire

// File: tb.sv
// Self-checking testbench of the linear pixel window unpacker
`timescale 1ns/1ps
`default_nettype none

module tb;
	import lfu_pkg::*;
	localparam logic [89:0] M_COL  = {90{1'b1}} << 40;
	localparam logic [89:0] M_COLA = M_COL | (90'hff << 32);
	localparam logic [89:0] M_NOA  = ~(90'hff << 32);
	localparam logic [89:0] M_NXY  = {90{1'b1}} >> 20;
	localparam logic [89:0] M_DEP  = (90'h3f << 64) | (90'hffff << 16);
	localparam logic [89:0] M_PIPE = ~(90'h7 << 64);
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, win_wr_data, win_rd_data, mem_rd_data, rd;
	logic        win_wr_valid, win_wr_ready, win_rd_req, win_rd_ready, win_rd_valid;
	logic [21:0] win_wr_addr, win_rd_addr;
	logic        mem_rd_req, mem_rd_valid, pix_valid, pix_pipe, er;
	logic        pix_color_we, pix_depth_we, pix_alpha_we;
	logic [9:0]  mem_rd_x, mem_rd_y, pix_x, pix_y;
	logic [1:0]  mem_rd_buf, pix_buf;
	logic [7:0]  pix_r, pix_g, pix_b, pix_a;
	logic [15:0] pix_depth, pix_w;
	logic [3:0]  lat;
	logic [31:0] mw;
	logic [89:0] q[$];
	int          miscompares = 0;
	int          checked = 0;

	lfu_unpacker dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .win_wr_valid(win_wr_valid), .win_wr_ready(win_wr_ready),
		.win_wr_addr(win_wr_addr), .win_wr_data(win_wr_data), .win_rd_req(win_rd_req),
		.win_rd_ready(win_rd_ready), .win_rd_addr(win_rd_addr), .win_rd_valid(win_rd_valid),
		.win_rd_data(win_rd_data), .mem_rd_req(mem_rd_req), .mem_rd_x(mem_rd_x),
		.mem_rd_y(mem_rd_y), .mem_rd_buf(mem_rd_buf), .mem_rd_valid(mem_rd_valid),
		.mem_rd_data(mem_rd_data), .pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y),
		.pix_buf(pix_buf), .pix_pipe(pix_pipe), .pix_color_we(pix_color_we),
		.pix_depth_we(pix_depth_we), .pix_alpha_we(pix_alpha_we), .pix_r(pix_r),
		.pix_g(pix_g), .pix_b(pix_b), .pix_a(pix_a), .pix_depth(pix_depth), .pix_w(pix_w));

	lfu_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_rd_req(mem_rd_req),
		.mem_rd_x(mem_rd_x), .mem_rd_y(mem_rd_y), .mem_rd_buf(mem_rd_buf), .lat(lat),
		.mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Collect every emitted pixel with all its fields
	always @(posedge pclk) begin
		if (pix_valid === 1'b1)
			q.push_back({pix_x, pix_y, pix_buf, pix_pipe, pix_color_we, pix_depth_we,
				pix_alpha_we, pix_r, pix_g, pix_b, pix_a, pix_depth, pix_w});
	end

	function automatic logic [89:0] px(input logic [9:0] x, y, input logic [5:0] c,
		input logic [7:0] r, g, b, a, input logic [15:0] d, w);
		return {x, y, c, r, g, b, a, d, w};
	endfunction

	task automatic final_report();
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cmp_word(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmp_pix(input logic [89:0] e, g, m);
		checked++;
		if ((g & m) !== (e & m)) begin
			miscompares++;
			$display("BAD pixel expected %h seen %h", e & m, g & m);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Host access is window base plus byte offset; the offset alone reaches the block
	task automatic wwrite(input logic [21:0] a, input logic [31:0] d);
		win_wr_valid <= 1'b1;
		win_wr_addr <= a;
		win_wr_data <= d;
		@(posedge pclk);
		while (win_wr_ready !== 1'b1)
			@(posedge pclk);
		win_wr_valid <= 1'b0;
	endtask

	task automatic rread(input logic [21:0] a, input logic [3:0] l);
		lat <= l;
		win_rd_req <= 1'b1;
		win_rd_addr <= a;
		@(posedge pclk);
		while (win_rd_ready !== 1'b1)
			@(posedge pclk);
		win_rd_req <= 1'b0;
		@(posedge pclk);
		while (win_rd_valid !== 1'b1)
			@(posedge pclk);
		rd = win_rd_data;
	endtask

	task automatic wcase(input logic [31:0] md, rm, input logic [21:0] a,
		input logic [31:0] d, input int np, input logic [89:0] e0, e1, m);
		apb(1'b1, 12'h000, md);
		apb(1'b1, 12'h008, rm);
		q.delete();
		wwrite(a, d);
		repeat (3) @(posedge pclk);
		cmp_word("pixel count", 32'(np), 32'(q.size()));
		if (np > 0)
			cmp_pix(e0, q[0], m);
		if (np > 1)
			cmp_pix(e1, q[1], m);
	endtask

	initial begin
		#200000;
		miscompares++;
		final_report();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, win_wr_valid, win_rd_req} = 5'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		win_wr_addr = 22'h0;
		win_wr_data = 32'h0;
		win_rd_addr = 22'h0;
		lat = 4'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		cmp_word("mode reset", 32'h0, rd);
		apb(1'b0, 12'h00c, 32'h0);
		cmp_word("height reset", 32'h3ff, rd);
		apb(1'b1, 12'h000, 32'hffffffff);
		apb(1'b0, 12'h000, 32'h0);
		cmp_word("mode readback", 32'h0001ffff, rd);
		apb(1'b0, 12'h020, 32'h0);
		cmp_word("unmapped read", 32'h0, rd);
		cmp_word("unmapped error", 32'h1, {31'h0, er});
		apb(1'b1, 12'h004, 32'h5a001234);
		wcase(32'h0, 32'h0, 22'h00100c, 32'h001ff800, 2,
			px(10'd6, 10'd2, 6'h04, 8'hff, 8'h0, 8'h0, 8'h0, 16'h0, 16'h0),
			px(10'd7, 10'd2, 6'h04, 8'h0, 8'h0, 8'hff, 8'h0, 16'h0, 16'h0), M_COL);
		wcase(32'h0800, 32'h0, 22'h00100c, 32'h001ff800, 2,
			px(10'd6, 10'd2, 6'h04, 8'h0, 8'h0, 8'hff, 8'h0, 16'h0, 16'h0),
			px(10'd7, 10'd2, 6'h04, 8'hff, 8'h0, 8'h0, 8'h0, 16'h0, 16'h0), M_COL);
		wcase(32'h000c, 32'h0, 22'h00201c, 32'hbeef07e0, 1,
			px(10'd7, 10'd2, 6'h06, 8'h0, 8'hff, 8'h0, 8'h0, 16'hbeef, 16'hbeef), 90'h0,
			M_NOA);
		wcase(32'h000f, 32'h0, 22'h00100c, 32'h22221111, 2,
			px(10'd0, 10'd0, 6'h02, 8'h0, 8'h0, 8'h0, 8'h0, 16'h1111, 16'h0),
			px(10'd0, 10'd0, 6'h02, 8'h0, 8'h0, 8'h0, 8'h0, 16'h2222, 16'h0), M_DEP);
		wcase(32'h080f, 32'h0, 22'h00100c, 32'h22221111, 2,
			px(10'd0, 10'd0, 6'h02, 8'h0, 8'h0, 8'h0, 8'h0, 16'h2222, 16'h0),
			px(10'd0, 10'd0, 6'h02, 8'h0, 8'h0, 8'h0, 8'h0, 16'h1111, 16'h0), M_DEP);
		wcase(32'h0003, 32'h0, 22'h00100c, 32'h12345678, 0, 90'h0, 90'h0, 90'h0);
		apb(1'b0, 12'h010, 32'h0);
		cmp_word("discard count", 32'h00010000, rd);
		wcase(32'h1805, 32'h0, 22'h00201c, 32'h11223344, 1,
			px(10'd7, 10'd2, 6'h04, 8'h33, 8'h22, 8'h11, 8'h0, 16'h0, 16'h0), 90'h0, M_COL);
		wcase(32'h0405, 32'h00040000, 22'h00201c, 32'h11223344, 1,
			px(10'd7, 10'd2, 6'h05, 8'h11, 8'h22, 8'h33, 8'h44, 16'h0, 16'h0), 90'h0, M_COLA);
		wcase(32'h000e, 32'h00040000, 22'h00201c, 32'hbeef8000, 1,
			px(10'd7, 10'd2, 6'h05, 8'h0, 8'h0, 8'h0, 8'hff, 16'h0, 16'h0), 90'h0,
			M_COLA);
		wcase(32'h0100, 32'h00020000, 22'h00100c, 32'h001ff800, 2,
			px(10'd6, 10'h3fd, 6'h08, 8'hff, 8'h0, 8'h0, 8'h5a, 16'h1234, 16'h1234),
			px(10'd7, 10'h3fd, 6'h08, 8'h0, 8'h0, 8'hff, 8'h5a, 16'h1234, 16'h1234), M_PIPE);
		wcase(32'h410c, 32'h0, 22'h00201c, 32'hbeef07e0, 1,
			px(10'd7, 10'd2, 6'h08, 8'h0, 8'hff, 8'h0, 8'h5a, 16'hbeef, 16'h1234), 90'h0,
			M_PIPE);
		wcase(32'h2010, 32'h0, 22'h00100c, 32'h001ff800, 2,
			px(10'd6, 10'h3fd, 6'h14, 8'hff, 8'h0, 8'h0, 8'h0, 16'h0, 16'h0),
			px(10'd7, 10'h3fd, 6'h14, 8'h0, 8'h0, 8'hff, 8'h0, 16'h0, 16'h0), M_COL);
		apb(1'b1, 12'h000, 32'h00018080);
		rread(22'h001810, 4'h0);
		mw = {2'h2, 4'h5, 10'd3, 6'h00, 10'd8};
		cmp_word("depth read swapped", {mw[23:16], mw[31:24], mw[7:0], mw[15:8]}, rd);
		apb(1'b1, 12'h000, 32'h2040);
		rread(22'h001810, 4'h6);
		cmp_word("back read slow", {2'h1, 4'h5, 10'h3fc, 6'h00, 10'd8}, rd);
		apb(1'b1, 12'h000, 32'h00c0);
		rread(22'h001810, 4'h0);
		cmp_word("reserved read", 32'h0, rd);
		final_report();
	end
endmodule

`default_nettype wire
